//--- rtl/sor_pkg.sv
// Package: constants and carrier types for the synchronous OTP read control
package sor_pkg;
  localparam int SOR_CLK_MHZ = 40;
  localparam int SOR_CLOCK_GATE_DELAY = 1;
  localparam int SOR_MASK_TO_OUTPUT_DELAY = 2;
  localparam int SOR_MODESET_TO_ROWOPEN_DELAY = 3;
  localparam logic [2:0] SOR_LATENCY_RESET = 3'h5;
  localparam logic [3:0] SOR_BURST_RESET = 4'h4;
  localparam int SOR_LAT_MAX = 8;
  localparam int SOR_ROW_W = 13;
  localparam int SOR_COL_W = 9;
  localparam int SOR_DATA_W = 16;
  // Mode word field layout: [2:0] latency, [3] burst of eight
  localparam int SOR_MODE_LAT_LSB = 0;
  localparam int SOR_MODE_BL8_BIT = 3;

  typedef enum logic [2:0] {
    SOR_CMD_NOP,
    SOR_CMD_MODESET,
    SOR_CMD_ROWOPEN,
    SOR_CMD_READ,
    SOR_CMD_TERMINATE,
    SOR_CMD_ROWCLOSE
  } sor_cmd_t;

  typedef struct packed {
    sor_cmd_t cmd;
    logic [SOR_ROW_W-1:0] addr;
  } sor_req_t;

  typedef struct packed {
    logic valid;
    logic [SOR_ROW_W-1:0] row;
    logic [SOR_COL_W-1:0] col;
  } sor_fetch_t;
endpackage : sor_pkg

//--- rtl/sor_delay_line.sv
// Fixed-length shift line with a hold input, used for mask timing
`timescale 1ns/1ps
module sor_delay_line
  import sor_pkg::*;
#(
  parameter int DEPTH = 2
)(
  input wire logic clk,
  input wire logic resetn,
  input wire logic hold,
  input wire logic din,
  output logic dout
);
  logic [DEPTH-1:0] line;

  always_ff @(posedge clk)
  begin
    if (!resetn)
      line <= '0;
    else if (!hold)
      line <= {line[DEPTH-2:0], din};
  end

  assign dout = line[DEPTH-1];
endmodule : sor_delay_line

//--- rtl/sor_latency_pipe.sv
// Latency pipeline carrying fetch requests, tap chosen at run time
`timescale 1ns/1ps
module sor_latency_pipe
  import sor_pkg::*;
#(
  parameter int DEPTH = SOR_LAT_MAX
)(
  input wire logic clk,
  input wire logic resetn,
  input wire logic hold,
  input wire logic [2:0] tap,
  input sor_fetch_t din,
  output sor_fetch_t dout
);
  sor_fetch_t stage [DEPTH];

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < DEPTH; i++)
        stage[i] <= '0;
    end
    else if (!hold)
    begin
      stage[0] <= din;
      for (int i = 1; i < DEPTH; i++)
        stage[i] <= stage[i-1];
    end
  end

  // Tap 1 means the entry appears one edge after the request
  always_comb
  begin
    dout = '0;
    if (tap != 3'h0)
      dout = stage[tap - 3'h1];
  end
endmodule : sor_latency_pipe

//--- rtl/sor_read_control.sv
// Read-port control: clock gating, power down, masking, bursts and command cancel
`timescale 1ns/1ps
module sor_read_control
  import sor_pkg::*;
#(
  parameter int ROW_W = SOR_ROW_W,
  parameter int COL_W = SOR_COL_W,
  parameter int DATA_W = SOR_DATA_W
)(
  input wire logic clk,
  input wire logic resetn,
  input wire logic clock_gate,
  input wire logic out_mask,
  input sor_req_t req,
  input wire logic [DATA_W-1:0] array_data,
  output logic [ROW_W-1:0] array_row,
  output logic [COL_W-1:0] array_col,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe,
  output logic powered_down,
  output logic suspended,
  output logic [2:0] read_latency_setting,
  output logic burst_of_eight
);
  typedef enum {
    SOR_IDLE,
    SOR_ROW_OPEN,
    SOR_READING,
    SOR_POWER_DOWN
  } sor_state_t;

  sor_state_t state;
  logic gate_q;
  logic edge_ok;
  logic read_active;
  logic [ROW_W-1:0] open_row;
  logic [COL_W-1:0] burst_col;
  logic [3:0] burst_left;
  logic [2:0] float_cnt;
  logic float_pend;
  logic mask_late;
  logic data_drive;
  sor_fetch_t fetch_in;
  sor_fetch_t fetch_out;
  logic [3:0] next_burst_left;
  logic [3:0] drain_cnt;

  function automatic logic [3:0] sor_burst_len(input logic bl8);
    sor_burst_len = bl8 ? 4'h8 : SOR_BURST_RESET;
  endfunction : sor_burst_len

  // Gate sampled last edge decides whether this edge counts
  always_ff @(posedge clk)
  begin
    if (!resetn)
      gate_q <= 1'b1;
    else
      gate_q <= clock_gate;
  end

  assign edge_ok = gate_q;
  assign read_active = (burst_left != 4'h0) || fetch_out.valid || (drain_cnt != 4'h0);
  assign suspended = !edge_ok && (state != SOR_POWER_DOWN);
  assign powered_down = (state == SOR_POWER_DOWN);

  // Mode settings survive power down; no reset sequence needed by the array
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      read_latency_setting <= SOR_LATENCY_RESET;
      burst_of_eight <= 1'b0;
    end
    else if (edge_ok && state != SOR_POWER_DOWN && req.cmd == SOR_CMD_MODESET)
    begin
      read_latency_setting <= req.addr[SOR_MODE_LAT_LSB +: 3];
      burst_of_eight <= req.addr[SOR_MODE_BL8_BIT];
    end
  end

  // Main state; mode-set to row-open spacing is left to the command source
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state <= SOR_IDLE;
      open_row <= '0;
    end
    else
    begin
      case (state)
        SOR_POWER_DOWN:
          // Commands dropped here; row kept for exit
          if (clock_gate)
            state <= SOR_ROW_OPEN;
        default:
          if (!clock_gate && state == SOR_ROW_OPEN && !read_active && edge_ok)
            state <= SOR_POWER_DOWN;
          else if (edge_ok)
          begin
            // Latest row open wins over anything still in flight
            if (req.cmd == SOR_CMD_ROWOPEN)
            begin
              open_row <= req.addr;
              state <= SOR_ROW_OPEN;
            end
            else if (req.cmd == SOR_CMD_READ && state != SOR_IDLE)
              state <= SOR_READING;
            else if (req.cmd == SOR_CMD_ROWCLOSE)
              state <= SOR_IDLE;
            else if (state == SOR_READING && !read_active)
              state <= SOR_ROW_OPEN;
          end
          // Low gate mid-read only freezes, never powers down
      endcase
    end
  end

  // Burst address walk, restarted by any newer read
  always_comb
  begin
    next_burst_left = burst_left;
    if (req.cmd == SOR_CMD_READ && state != SOR_IDLE && state != SOR_POWER_DOWN)
      next_burst_left = sor_burst_len(burst_of_eight);
    else if (req.cmd == SOR_CMD_TERMINATE || req.cmd == SOR_CMD_ROWCLOSE
             || req.cmd == SOR_CMD_ROWOPEN)
      next_burst_left = 4'h0;
    else if (burst_left != 4'h0)
      next_burst_left = burst_left - 4'h1;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      burst_left <= 4'h0;
      burst_col <= '0;
    end
    else if (edge_ok && state != SOR_POWER_DOWN)
    begin
      burst_left <= next_burst_left;
      if (req.cmd == SOR_CMD_READ && state != SOR_IDLE)
        burst_col <= req.addr[COL_W-1:0];
      else if (burst_left != 4'h0)
        burst_col <= burst_col + {{(COL_W-1){1'b0}}, 1'b1};
    end
  end

  // Pipeline still carries fetches after the burst counter runs out
  always_ff @(posedge clk)
  begin
    if (!resetn)
      drain_cnt <= 4'h0;
    else if (edge_ok && state != SOR_POWER_DOWN)
    begin
      if (burst_left != 4'h0)
        drain_cnt <= {1'b0, read_latency_setting};
      else if (drain_cnt != 4'h0)
        drain_cnt <= drain_cnt - 4'h1;
    end
  end

  assign fetch_in.valid = edge_ok && (burst_left != 4'h0) && (state != SOR_POWER_DOWN);
  assign fetch_in.row = open_row;
  assign fetch_in.col = burst_col;
  assign array_row = fetch_out.row;
  assign array_col = fetch_out.col;

  sor_latency_pipe #(
    .DEPTH(SOR_LAT_MAX)
  ) u_pipe (
    .clk(clk),
    .resetn(resetn),
    .hold(!edge_ok),
    .tap(read_latency_setting),
    .din(fetch_in),
    .dout(fetch_out)
  );

  // Terminate and row close float the bus after the latency
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      float_pend <= 1'b0;
      float_cnt <= 3'h0;
    end
    else if (edge_ok && state != SOR_POWER_DOWN)
    begin
      if (req.cmd == SOR_CMD_TERMINATE || req.cmd == SOR_CMD_ROWCLOSE)
      begin
        float_pend <= 1'b1;
        float_cnt <= read_latency_setting - 3'h1;
      end
      else if (req.cmd == SOR_CMD_READ)
        float_pend <= 1'b0;
      else if (float_pend && float_cnt != 3'h0)
        float_cnt <= float_cnt - 3'h1;
      else
        float_pend <= 1'b0;
    end
  end

  // Mask delay runs on the raw clock so its timing is fixed
  sor_delay_line #(
    .DEPTH(SOR_MASK_TO_OUTPUT_DELAY)
  ) u_mask (
    .clk(clk),
    .resetn(resetn),
    .hold(1'b0),
    .din(out_mask),
    .dout(mask_late)
  );

  // Output word; frozen during suspend so the bus stays stable
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      dq_out <= '0;
      data_drive <= 1'b0;
    end
    else if (edge_ok)
    begin
      if (fetch_out.valid)
        dq_out <= array_data;
      // Float wins over words still leaving the pipeline
      if (float_pend && float_cnt == 3'h0)
        data_drive <= 1'b0;
      else if (fetch_out.valid)
        data_drive <= 1'b1;
      else if (!read_active)
        data_drive <= 1'b0;
    end
  end

  assign dq_oe = data_drive && !mask_late;

  a_mask_floats: assert property (@(posedge clk) disable iff (!resetn)
    out_mask |-> ##2 !dq_oe)
    else $error("mask did not float outputs after two cycles");

  a_suspend_hold: assert property (@(posedge clk) disable iff (!resetn)
    !gate_q |=> $stable(dq_out) && $stable(burst_left))
    else $error("state moved during a suspended cycle");

  a_gate_edge: assert property (@(posedge clk) disable iff (!resetn)
    !clock_gate |=> !edge_ok)
    else $error("internal edge taken after low clock gate");

  a_gate_resume: assert property (@(posedge clk) disable iff (!resetn)
    clock_gate |=> edge_ok)
    else $error("internal edge not resumed after high clock gate");

  a_pd_entry: assert property (@(posedge clk) disable iff (!resetn)
    $rose(powered_down) |-> $past(state) == SOR_ROW_OPEN && !$past(read_active))
    else $error("power down entered outside row-open idle");

  a_pd_keep_row: assert property (@(posedge clk) disable iff (!resetn)
    powered_down |=> $stable(open_row) && $stable(read_latency_setting))
    else $error("row or mode changed in power down");

  a_pd_no_read: assert property (@(posedge clk) disable iff (!resetn)
    powered_down && req.cmd == SOR_CMD_READ |=> burst_left == $past(burst_left))
    else $error("command taken in power down");

  a_read_restart: assert property (@(posedge clk) disable iff (!resetn)
    edge_ok && req.cmd == SOR_CMD_READ && (state == SOR_ROW_OPEN || state == SOR_READING)
    |=> burst_left == sor_burst_len(burst_of_eight))
    else $error("new read did not restart the burst");

  a_suspend_not_pd: assert property (@(posedge clk) disable iff (!resetn)
    state == SOR_READING && !clock_gate |=> state != SOR_POWER_DOWN)
    else $error("power down entered during a read");

  a_float_stop: assert property (@(posedge clk) disable iff (!resetn)
    edge_ok && float_pend && float_cnt == 3'h0 |=> !dq_oe)
    else $error("outputs still driven after stop latency");

  a_read_idle: assert property (@(posedge clk) disable iff (!resetn)
    state == SOR_READING && edge_ok && !read_active && req.cmd == SOR_CMD_NOP
    |=> state == SOR_ROW_OPEN)
    else $error("finished read did not return to row-open idle");

  c_float: cover property (@(posedge clk) disable iff (!resetn) float_pend && !dq_oe);
  c_power_down: cover property (@(posedge clk) disable iff (!resetn) $rose(powered_down));
  c_suspend: cover property (@(posedge clk) disable iff (!resetn) suspended && read_active);
  c_mask: cover property (@(posedge clk) disable iff (!resetn) data_drive ##1 !dq_oe);
  c_preempt: cover property (@(posedge clk) disable iff (!resetn)
    burst_left > 4'h1 && edge_ok && req.cmd == SOR_CMD_READ);
endmodule : sor_read_control

//--- dv/sor_array_model.sv
// Array content model answering fetch addresses from the read control
`timescale 1ns/1ps
module sor_array_model
  import sor_pkg::*;
(
  input wire logic [SOR_ROW_W-1:0] row,
  input wire logic [SOR_COL_W-1:0] col,
  output logic [SOR_DATA_W-1:0] data
);
  // Pattern differs per column and per row[6:0] only, so rows alike in those bits read the same
  assign data = {row[6:0], col} ^ 16'hA5C3;
endmodule : sor_array_model

//--- dv/tb_top.sv
// Self-checking testbench for the synchronous read control
`timescale 1ns/1ps
module tb_top
  import sor_pkg::*;
;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic clock_gate = 1'b1;
  logic out_mask = 1'b0;
  sor_req_t req = '0;
  logic [15:0] array_data;
  logic [12:0] array_row;
  logic [8:0] array_col;
  logic [15:0] dq_out;
  logic dq_oe;
  logic powered_down;
  logic suspended;
  logic [2:0] read_latency_setting;
  logic burst_of_eight;
  int err_total = 0;
  int check_count = 0;
  logic [2:0] lat;
  logic [12:0] row;
  logic [8:0] col;
  sor_cmd_t cmds [2] = '{SOR_CMD_TERMINATE, SOR_CMD_ROWCLOSE};

  always #12.5 clk = ~clk;

  sor_read_control uut (.clk, .resetn, .clock_gate, .out_mask, .req, .array_data,
    .array_row, .array_col, .dq_out, .dq_oe, .powered_down, .suspended,
    .read_latency_setting, .burst_of_eight);
  sor_array_model mem (.row(array_row), .col(array_col), .data(array_data));

  function automatic logic [15:0] exp_word(input logic [12:0] r, input logic [8:0] c);
    return {r[6:0], c} ^ 16'hA5C3;
  endfunction : exp_word

  task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", name, e, g);
      err_total++;
    end
  endtask : chk

  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict

  task automatic issue(input sor_cmd_t c, input logic [12:0] a);
    @(posedge clk);
    req <= '{c, a};
  endtask : issue

  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge clk);
      req <= '{SOR_CMD_NOP, 13'h0};
    end
  endtask : tick

  // Bounded wait for the first driven word, left 1 ns past its edge
  task automatic wait_oe;
    int i;
    #1;
    for (i = 0; i < 30 && dq_oe !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
    end
    chk("dq_oe rise", 16'h1, {15'h0, dq_oe});
  endtask : wait_oe

  task automatic words(input logic [8:0] c, input int n);
    int k;
    for (k = 0; k < n; k++)
    begin
      chk("burst word", exp_word(row, c + 9'(k)), dq_out);
      @(posedge clk);
      #1;
    end
    chk("burst end", 16'h0, {15'h0, dq_oe});
  endtask : words

  task automatic read_start(input logic [8:0] c);
    issue(SOR_CMD_READ, {4'h0, c});
    tick(1);
    wait_oe();
  endtask : read_start

  initial
  begin
    void'($urandom(32'hFD6F));
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    #1;
    chk("oe reset", 16'h0, {15'h0, dq_oe});
    chk("latency reset", {13'h0, SOR_LATENCY_RESET}, {13'h0, read_latency_setting});
    chk("burst reset", 16'h0, {15'h0, burst_of_eight});
    lat = 3'h3 + 3'($urandom % 4);
    row = 13'($urandom);
    col = {6'($urandom), 3'h0};
    issue(SOR_CMD_MODESET, {9'h0, 1'b0, lat});
    tick(SOR_MODESET_TO_ROWOPEN_DELAY);
    issue(SOR_CMD_ROWOPEN, row);
    tick(2);
    read_start(col);
    words(col, 4);
    // Second read one cycle after the first
    issue(SOR_CMD_READ, {4'h0, col});
    issue(SOR_CMD_READ, {4'h0, col + 9'h8});
    tick(1);
    wait_oe();
    chk("cut word", exp_word(row, col), dq_out);
    @(posedge clk) #1;
    words(col + 9'h8, 4);
    issue(SOR_CMD_MODESET, {9'h0, 1'b1, lat});
    tick(SOR_MODESET_TO_ROWOPEN_DELAY);
    read_start(col);
    @(posedge clk) out_mask <= 1'b1;
    @(posedge clk) #1 chk("mask early", 16'h1, {15'h0, dq_oe});
    @(posedge clk) #1 chk("mask float", 16'h0, {15'h0, dq_oe});
    @(posedge clk) out_mask <= 1'b0;
    @(posedge clk) #1 chk("mask held", 16'h0, {15'h0, dq_oe});
    @(posedge clk) #1 chk("mask recover", 16'h1, {15'h0, dq_oe});
    words(col + 9'h6, 2);
    foreach (cmds[i])
    begin
      issue(SOR_CMD_ROWOPEN, row);
      tick(2);
      read_start(col);
      issue(cmds[i], 13'h0);
      tick(int'(lat));
      #1 chk("drive before float", 16'h1, {15'h0, dq_oe});
      @(posedge clk) #1 chk("float after stop", 16'h0, {15'h0, dq_oe});
    end
    issue(SOR_CMD_ROWOPEN, row);
    tick(2);
    read_start(col);
    @(posedge clk) clock_gate <= 1'b0;
    @(posedge clk) clock_gate <= 1'b1;
    #1 chk("suspend flag", 16'h1, {15'h0, suspended});
    chk("suspend word", exp_word(row, col + 9'h2), dq_out);
    chk("no power down", 16'h0, {15'h0, powered_down});
    @(posedge clk) #1 chk("suspend hold", exp_word(row, col + 9'h2), dq_out);
    @(posedge clk) #1 chk("resume word", exp_word(row, col + 9'h3), dq_out);
    tick(12);
    @(posedge clk) clock_gate <= 1'b0;
    tick(3);
    #1 chk("power down", 16'h1, {15'h0, powered_down});
    issue(SOR_CMD_MODESET, 13'h7);
    issue(SOR_CMD_READ, {4'h0, col});
    tick(1);
    @(posedge clk) clock_gate <= 1'b1;
    tick(3);
    #1 chk("mode kept", {13'h0, lat}, {13'h0, read_latency_setting});
    col = {6'($urandom), 3'h0};
    read_start(col);
    words(col, 8);
    give_verdict();
  end

  // Whole sequence needs under two hundred cycles
  initial
  begin
    #(25 * 4000);
    err_total++;
    give_verdict();
  end
endmodule : tb_top
